// >>> logic/pfs_oneshot.sv
/*
 * One-shot qualifier: the output follows a falling input at once and
 * rises only after the input has stayed high for COUNT clock cycles.
 * Assumes the input is synchronous to clk_in.
 */
`timescale 1ns/1ns
`default_nettype none

module pfs_oneshot #(
    parameter int unsigned COUNT = 1
) (
    input  wire logic clk_in,    // System clock
    input  wire logic rst_n_in,  // Asynchronous reset, active low
    input  wire logic level_in,  // Raw level
    output logic      level_out  // Qualified level, registered
);
    localparam int unsigned CW = $clog2(COUNT + 1);

    logic [CW-1:0] count;
    wire           done       = (count >= CW'(COUNT - 1));
    wire  [CW-1:0] next_count = !level_in ? '0 : (done ? count : count + CW'(1));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count     <= '0;
            level_out <= 1'b0;
        end else begin
            count     <= next_count;
            level_out <= level_in && done;
        end
    end

    // Never high unless the input was high the cycle before
    hold_qual_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        level_out |-> $past(level_in)) else $error("one-shot high without input");

endmodule // pfs_oneshot

`default_nettype wire

// >>> logic/pfs_pkg.sv
/*
 * Shared constants and types of the power fault supervisor: register
 * offsets, status bit positions, reset values and filter timings.
 * Assumes a 25 MHz system clock; all counts derive from it.
 */
package pfs_pkg;

    // Clock rate and filter times in their own units
    localparam int unsigned CLK_MHZ      = 25;
    localparam int unsigned PG_DELAY_US  = 1000;
    localparam int unsigned WARN_FILT_NS = 32000;
    localparam int unsigned ILIM_FILT_NS = 1024000;
    // Least times round up to whole cycles
    localparam int unsigned PG_DELAY_CYC  = PG_DELAY_US * CLK_MHZ;
    localparam int unsigned WARN_FILT_CYC = (WARN_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ILIM_FILT_CYC = (ILIM_FILT_NS * CLK_MHZ + 999) / 1000;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_STAT0 = 8'h05;
    localparam logic [7:0] ADDR_STAT1 = 8'h06;

    // Reset values
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] STAT_RST = 16'h0000;

    // Control field position
    localparam int unsigned CTRL_DIS_EN = 7;

    // Status bits: index into {status1, status0}
    localparam int unsigned S_IN5_WARN  = 0;
    localparam int unsigned S_IN12_WARN = 1;
    localparam int unsigned S_IN5_OT    = 2;
    localparam int unsigned S_IN12_OT   = 3;
    localparam int unsigned S_CORE_UV   = 4;
    localparam int unsigned S_IO_UV     = 5;
    localparam int unsigned S_IN5_UV    = 6;
    localparam int unsigned S_IN12_UV   = 7;
    localparam int unsigned S_IN5_OV    = 8;
    localparam int unsigned S_IN12_OV   = 9;
    localparam int unsigned S_DIS_PIN   = 11;
    localparam int unsigned S_CORE_OC   = 12;
    localparam int unsigned S_IO_OC     = 13;
    localparam int unsigned S_IN5_OC    = 14;
    localparam int unsigned S_IN12_OC   = 15;
    // Bit 10 is reserved and reads as zero
    localparam logic [15:0] STAT_MASK = 16'hfbff;

    // Comparator and analog status inputs, all active high
    typedef struct packed {
        logic in12_uvlo;     // 12V input below its falling threshold
        logic in5_uvlo;      // 5V input below its falling threshold
        logic in12_clamp;    // 12V eFuse output clamping
        logic in5_clamp;     // 5V eFuse output clamping
        logic in12_ilim;     // 12V eFuse in current limit
        logic in5_ilim;      // 5V eFuse in current limit
        logic in12_warm;     // 12V eFuse early temperature threshold
        logic in5_warm;      // 5V eFuse early temperature threshold
        logic in12_hot;      // 12V eFuse over temperature
        logic in5_hot;       // 5V eFuse over temperature
        logic in12_melt;     // 12V eFuse at 175 degC
        logic in5_melt;      // 5V eFuse at 175 degC
        logic core_low;      // Core rail 10% below target
        logic io_low;        // IO rail 10% below target
        logic core_short;    // Core rail below 70%
        logic io_short;      // IO rail below 70%
        logic core_ilim;     // Core switcher peak current limit
        logic io_ilim;       // IO switcher peak current limit
        logic backup_uv;     // Backup 5V node undervoltage
        logic io_soft_done;  // IO switcher soft start done
        logic out12_settled; // 12V output settled
    } pfs_sense_s;

endpackage

// >>> logic/pfs_supervisor.sv
/*
 * Fault supervisor of a power management device: power-good qualifying,
 * latched fault status, fault interrupt, eFuse and switcher permission,
 * thermal latch-offs and the backup regulator enable.
 * Assumes all inputs are synchronous to clk_in and that the housekeeping
 * supply drives rst_n_in, so its cycling clears every latch.
 */
`timescale 1ns/1ns
`default_nettype none

module pfs_supervisor
    import pfs_pkg::*;
#(
    parameter int unsigned PG_CYC   = PG_DELAY_CYC,
    parameter int unsigned ILIM_CYC = ILIM_FILT_CYC
) (
    input  wire logic       clk_in,                // 25 MHz system clock
    input  wire logic       rst_n_in,              // Async reset, active low
    input  wire pfs_sense_s sense_in,              // Comparator levels
    input  wire logic       power_disable_in,      // Power disable pin
    input  wire logic       fw_disable_allow_in,   // Firmware permission pin
    input  wire logic       core_switcher_enable_in, // Core switcher enable pin
    input  wire logic [7:0] addr_in,               // Register address
    input  wire logic [7:0] wdata_in,              // Register write data
    input  wire logic       wr_in,                 // Write strobe
    input  wire logic       rd_in,                 // Read strobe
    output logic      [7:0] rdata_out,             // Read data, cycle after strobe
    output logic            fault_irq_n_out,       // Fault interrupt, active low
    output logic            core_rail_good_out,    // Core rail power good
    output logic            io_rail_good_out,      // IO rail power good
    output logic            backup_reg_enable_out, // Backup regulator enable
    output logic            efuse12_close_out,     // 12V eFuse closed
    output logic            efuse5_close_out,      // 5V eFuse closed
    output logic            core_switcher_run_out, // Core switcher running
    output logic            io_switcher_run_out,   // IO switcher running
    output logic            core_hiccup_out,       // Core switcher hiccup mode
    output logic            io_hiccup_out          // IO switcher hiccup mode
);
    localparam int unsigned NQ = 9;

    logic [7:0]    ctrl;
    logic [15:0]   status;
    logic [15:0]   prev_lvl;
    logic          prev_pin;
    logic          prev_in5_uvlo;
    logic          melt12;
    logic          melt5;
    logic          late_5v;
    logic [NQ-1:0] qual;

    // Register decode
    wire wr_ctrl  = wr_in && (addr_in == ADDR_CTRL);
    wire wr_stat0 = wr_in && (addr_in == ADDR_STAT0);
    wire wr_stat1 = wr_in && (addr_in == ADDR_STAT1);
    wire [15:0] stat_clr = {wr_stat1 ? wdata_in : 8'h00, wr_stat0 ? wdata_in : 8'h00};
    wire [7:0] rd_sel = (addr_in == ADDR_CTRL)  ? ctrl :
                        (addr_in == ADDR_STAT0) ? status[7:0] :
                        (addr_in == ADDR_STAT1) ? status[15:8] : 8'h00;
    wire [7:0] next_rdata = rd_in ? rd_sel : 8'h00;

    wire dis_en = ctrl[CTRL_DIS_EN];
    wire dis_open = fw_disable_allow_in ? (power_disable_in && dis_en) : power_disable_in;

    // Pin edges and supply cycling
    wire pin_toggle = power_disable_in ^ prev_pin;
    wire pin_fall   = prev_pin && !power_disable_in;
    wire in5_lost   = sense_in.in5_uvlo && !prev_in5_uvlo;
    wire in5_back   = prev_in5_uvlo && !sense_in.in5_uvlo;
    wire in12_lost  = sense_in.in12_uvlo && !prev_lvl[S_IN12_UV];
    wire rel12 = in12_lost || pin_fall || in5_lost;
    wire rel5 = pin_fall || in5_lost;

    // short is low rail plus current limit
    wire core_short = sense_in.core_short && sense_in.core_ilim;
    wire io_short   = sense_in.io_short && sense_in.io_ilim;

    // Switcher permission, the 5V latch and backup undervoltage stop both
    // 5V latch stops switchers
    wire next_core_run = core_switcher_enable_in && !melt5 && !sense_in.backup_uv;
    wire next_io_run   = !melt5 && !sense_in.backup_uv;

    wire next_ef12 = !sense_in.in12_uvlo && !sense_in.in12_hot && !melt12 &&
                     !dis_open && !sense_in.backup_uv;
    wire next_ef5  = !sense_in.in5_uvlo && !sense_in.in5_hot && !melt5 &&
                     !dis_open && !sense_in.backup_uv;

    wire next_late_5v = (in5_back && sense_in.out12_settled) ||
                        (late_5v && !sense_in.in5_uvlo);

    // Raw levels into the one-shot qualifiers
    wire [NQ-1:0] raw;
    // rail good needs rail above threshold
    assign raw[0] = !sense_in.core_low && !core_short && core_switcher_run_out;
    assign raw[1] = !sense_in.io_low && !io_short && io_switcher_run_out;
    // backup enable gated by soft start
    assign raw[2] = efuse5_close_out && sense_in.io_soft_done && !late_5v;
    assign raw[3] = sense_in.in12_ilim;
    assign raw[4] = sense_in.in5_ilim;
    assign raw[5] = sense_in.core_ilim;
    assign raw[6] = sense_in.io_ilim;
    assign raw[7] = sense_in.in12_warm;
    assign raw[8] = sense_in.in5_warm;

    // 1 ms deglitch of power good and backup enable; eFuse current limits use ILIM_CYC, switcher current limits and warnings WARN_FILT_CYC
    generate
        for (genvar i = 0; i < NQ; i++) begin : g_qual
            localparam int unsigned N = (i < 3) ? PG_CYC :
                                        (i < 5) ? ILIM_CYC : WARN_FILT_CYC;
            pfs_oneshot #(
                .COUNT     (N)
            ) u_qual (
                .clk_in    (clk_in),
                .rst_n_in  (rst_n_in),
                .level_in  (raw[i]),
                .level_out (qual[i])
            );
        end
    endgenerate

    // Fault levels in status bit order; a rising level records a fault
    wire [15:0] lvl;
    assign lvl[S_IN5_WARN]  = qual[8];
    assign lvl[S_IN12_WARN] = qual[7];
    assign lvl[S_IN5_OT]    = sense_in.in5_hot;
    assign lvl[S_IN12_OT]   = sense_in.in12_hot;
    // undervolt and short share the bit
    assign lvl[S_CORE_UV]   = sense_in.core_low || core_short;
    assign lvl[S_IO_UV]     = sense_in.io_low || io_short;
    assign lvl[S_IN5_UV]    = sense_in.in5_uvlo;
    assign lvl[S_IN12_UV]   = sense_in.in12_uvlo;
    assign lvl[S_IN5_OV]    = sense_in.in5_clamp;
    assign lvl[S_IN12_OV]   = sense_in.in12_clamp;
    assign lvl[10]          = 1'b0;
    assign lvl[S_DIS_PIN]   = dis_open;
    assign lvl[S_CORE_OC]   = qual[5];
    assign lvl[S_IO_OC]     = qual[6];
    assign lvl[S_IN5_OC]    = qual[4];
    assign lvl[S_IN12_OC]   = qual[3];

    wire [15:0] pin_ev   = {4'h0, pin_toggle, 11'h000};
    wire [15:0] stat_set = ((lvl & ~prev_lvl) | pin_ev) & STAT_MASK;
    wire [15:0] next_status = (status & ~stat_clr) | stat_set;
    wire next_irq_n = !(|next_status) && !sense_in.backup_uv;

    wire next_melt12 = sense_in.in12_melt || (melt12 && !rel12);
    wire next_melt5  = sense_in.in5_melt || (melt5 && !rel5);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl      <= CTRL_RST;
            rdata_out <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata_in;
            end
            rdata_out <= next_rdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status          <= STAT_RST;
            prev_lvl        <= 16'h0000;
            prev_pin        <= 1'b0;
            prev_in5_uvlo   <= 1'b0;
            fault_irq_n_out <= 1'b1;
        end else begin
            status          <= next_status;
            prev_lvl        <= lvl;
            prev_pin        <= power_disable_in;
            prev_in5_uvlo   <= sense_in.in5_uvlo;
            fault_irq_n_out <= next_irq_n;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            melt12  <= 1'b0;
            melt5   <= 1'b0;
            late_5v <= 1'b0;
        end else begin
            melt12  <= next_melt12;
            melt5   <= next_melt5;
            late_5v <= next_late_5v;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            efuse12_close_out     <= 1'b0;
            efuse5_close_out      <= 1'b0;
            core_switcher_run_out <= 1'b0;
            io_switcher_run_out   <= 1'b0;
            core_hiccup_out       <= 1'b0;
            io_hiccup_out         <= 1'b0;
        end else begin
            efuse12_close_out     <= next_ef12;
            efuse5_close_out      <= next_ef5;
            core_switcher_run_out <= next_core_run;
            io_switcher_run_out   <= next_io_run;
            core_hiccup_out       <= core_short;
            io_hiccup_out         <= io_short;
        end
    end

    // Power good and backup enable come straight from the qualifier flops
    assign core_rail_good_out    = qual[0];
    assign io_rail_good_out      = qual[1];
    assign backup_reg_enable_out = qual[2];

    pg_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sense_in.core_low |=> !core_rail_good_out)
        else $error("core power good not dropped");

    pg_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(io_rail_good_out) |-> $past(raw[1], 1) && $past(raw[1], 8))
        else $error("io power good rose before delay");

    irq_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|stat_set) |=> !fault_irq_n_out && (status & $past(stat_set)) == $past(stat_set))
        else $error("fault not latched or interrupt idle");

    irq_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|status) |-> !fault_irq_n_out)
        else $error("interrupt released with fault latched");

    efuse_perm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (power_disable_in && (!fw_disable_allow_in || dis_en))
        |=> !efuse12_close_out && !efuse5_close_out)
        else $error("eFuse closed while disabled");

    melt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        melt12 && !rel12 |=> melt12 && !efuse12_close_out)
        else $error("12V thermal latch lost");

    melt5_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        melt5 |=> !efuse5_close_out && !io_switcher_run_out && !core_switcher_run_out)
        else $error("5V thermal latch not holding");

    backup_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sense_in.io_soft_done |=> !backup_reg_enable_out)
        else $error("backup enable before soft start");

    in12_undervolt_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sense_in.in12_uvlo) |=> !efuse12_close_out && status[S_IN12_UV])
        else $error("12V undervoltage not handled");

    backup_uv_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sense_in.backup_uv |=> !fault_irq_n_out && !efuse5_close_out && !io_switcher_run_out)
        else $error("backup undervoltage not handled");

    stat_clr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_stat0 && wdata_in[S_IN5_UV] && !stat_set[S_IN5_UV] |=> !status[S_IN5_UV])
        else $error("status bit not cleared by write");

    warn_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(qual[8]) |=> status[S_IN5_WARN] && !fault_irq_n_out)
        else $error("early warning not flagged");

    hot_open_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sense_in.in12_hot) |=> !efuse12_close_out && status[S_IN12_OT])
        else $error("12V over temperature not handled");

    late5_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        late_5v |=> !backup_reg_enable_out)
        else $error("backup enable after late 5V");

    backup_dgl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(backup_reg_enable_out) |-> $past(raw[2], 1) && $past(raw[2], 8))
        else $error("backup enable rose before deglitch");

    uv5_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sense_in.in5_uvlo) |=> !efuse5_close_out && status[S_IN5_UV])
        else $error("5V undervoltage not handled");

    ov_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sense_in.in12_clamp) |=> status[S_IN12_OV] && !fault_irq_n_out)
        else $error("12V overvoltage not flagged");

    rail_uv_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sense_in.io_low) && !io_short && !$past(io_short) && !melt5 && !sense_in.backup_uv
        |=> status[S_IO_UV] && !io_rail_good_out && io_switcher_run_out)
        else $error("io rail undervoltage not handled");

    short_hiccup_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        core_short |=> core_hiccup_out && !core_rail_good_out)
        else $error("core short not in hiccup");

    oc_free_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        status[S_CORE_OC] && $rose(io_short) && !$past(sense_in.io_low) |=> status[S_IO_UV])
        else $error("status locked by switcher current limit");

    pin_state_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(dis_open) |=> status[S_DIS_PIN] && !fault_irq_n_out)
        else $error("power disable state not flagged");

    ctrl_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ctrl |=> dis_en == $past(wdata_in[CTRL_DIS_EN]))
        else $error("disable enable bit not written");

    short_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        core_hiccup_out && io_hiccup_out);
    pg_rise_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(core_rail_good_out));
    irq_cycle_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        !fault_irq_n_out ##1 fault_irq_n_out);
    melt_rel_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        melt12 ##1 !melt12);

endmodule // pfs_supervisor

`default_nettype wire

// >>> verif/pfs_host.sv
/* Host processor model: register bus master that services the fault
   interrupt. Assumes callers start its tasks at or after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module pfs_host (
    input  wire logic       clk_in,    // System clock
    input  wire logic       irq_n_in,  // Fault interrupt, active low
    output logic      [7:0] addr_out,  // Register address
    output logic      [7:0] wdata_out, // Write data
    output logic            wr_out,    // Write strobe
    output logic            rd_out     // Read strobe
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Leading edge wait keeps back-to-back strobes from colliding
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
    endtask
    task automatic clear_faults();
        if (irq_n_in !== 1'b1) begin
            reg_write(8'h05, 8'hff);
            reg_write(8'h06, 8'hff);
        end
    endtask
endmodule // pfs_host
`default_nettype wire

// >>> verif/testbench.sv
/* Bench of the fault supervisor: drives sense levels and pins, talks to
   registers through the host model. Assumes pfs_pkg is compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import pfs_pkg::*;
();
    localparam int unsigned PG = 10;
    logic       clk_in = 1'b0;
    logic       rst_n = 1'b0;
    pfs_sense_s sense = '0;
    logic       pin = 1'b0;
    logic       allow = 1'b0;
    logic       cen = 1'b1;
    logic       rd_q = 1'b0;
    logic [7:0] addr, wdata, rdata, c;
    logic       wr, rd, irq_n, cg, ig, ch, ih, bk, e12, e5, crun, irun;
    logic [15:0] s;
    int         comparisons = 0;
    int         bad_count = 0;
    logic [7:0] exp_q[$];
    int unsigned sn[14] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 11, 8, 7, 4, 3};
    int unsigned st[14] = '{7, 6, 9, 8, 15, 14, 1, 0, 3, 2, 4, 5, 12, 13};
    logic [1:0] ef[14] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3,
                           2'h3, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    pfs_supervisor #(.PG_CYC(PG), .ILIM_CYC(12)) i_pfs_supervisor (
        .clk_in(clk_in), .rst_n_in(rst_n), .sense_in(sense),
        .power_disable_in(pin), .fw_disable_allow_in(allow),
        .core_switcher_enable_in(cen), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .fault_irq_n_out(irq_n),
        .core_rail_good_out(cg), .io_rail_good_out(ig), .backup_reg_enable_out(bk),
        .efuse12_close_out(e12), .efuse5_close_out(e5), .core_switcher_run_out(crun),
        .io_switcher_run_out(irun), .core_hiccup_out(ch), .io_hiccup_out(ih));
    pfs_host i_pfs_host (.clk_in(clk_in), .irq_n_in(irq_n), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    task automatic end_of_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_lvl(input logic g, input logic e);
        check_reg({7'h00, g}, {7'h00, e});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_pfs_host.reg_read(a);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Outputs are looked at mid-cycle, once the edge's updates have landed
    task automatic peek();
        @(negedge clk_in);
    endtask
    always @(posedge clk_in) rd_q <= rd;
    always @(negedge clk_in) begin
        if (rd_q === 1'b1) begin
            check_reg(rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(15484));
        tick(12);
        rst_n <= 1'b1;
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h07, 8'h00);
        tick(40);
        peek();
        check_lvl(bk, 1'b0);
        tick(1);
        sense.io_soft_done <= 1'b1;
        tick(8);
        peek();
        check_lvl(bk, 1'b0);
        tick(20);
        peek();
        check_lvl(bk, 1'b1);
        tick(1);
        sense.io_soft_done <= 1'b0;
        tick(2);
        sense.io_soft_done <= 1'b1;
        tick(3);
        peek();
        check_lvl(bk, 1'b0);
        tick(1);
        sense.out12_settled <= 1'b1;
        sense.in5_uvlo <= 1'b1;
        tick(2);
        sense.in5_uvlo <= 1'b0;
        tick(30);
        peek();
        check_lvl(bk, 1'b0);
        tick(1);
        sense.out12_settled <= 1'b0;
        i_pfs_host.clear_faults();
        for (int i = 0; i < 14; i++) begin
            s = 16'h0001 << st[i];
            sense[sn[i]] <= 1'b1;
            tick(900);
            peek();
            check_lvl(e12, ef[i][1]);
            check_lvl(e5, ef[i][0]);
            check_lvl(irq_n, 1'b0);
            if (sn[i] == 8) check_lvl(cg, 1'b0);
            if (sn[i] == 7) check_lvl(ig, 1'b0);
            rd_chk(8'h05, s[7:0]);
            rd_chk(8'h06, s[15:8]);
            i_pfs_host.clear_faults();
            peek();
            check_lvl(irq_n, 1'b1);
            tick(1);
            sense[sn[i]] <= 1'b0;
            tick(5);
            peek();
            if (sn[i] == 8) check_lvl(cg, 1'b0);
            if (sn[i] == 7) check_lvl(ig, 1'b0);
            tick(25);
            peek();
            check_lvl(cg & ig, 1'b1);
            tick(1);
        end
        for (int k = 0; k < 8; k++) begin
            allow <= k[2];
            c = {k[1], 7'($urandom)};
            i_pfs_host.reg_write(8'h04, c);
            rd_chk(8'h04, c);
            pin <= k[0];
            tick(3);
            peek();
            check_lvl(e12, !(k[2] ? k[0] & k[1] : k[0]));
            check_lvl(e5, !(k[2] ? k[0] & k[1] : k[0]));
            rd_chk(8'h06, {4'h0, k[0], 3'h0});
            pin <= 1'b0;
            tick(3);
            i_pfs_host.clear_faults();
            peek();
            check_lvl(irq_n, 1'b1);
            tick(1);
        end
        sense.core_ilim <= 1'b1;
        sense.io_ilim <= 1'b1;
        tick(900);
        sense.core_short <= 1'b1;
        sense.io_short <= 1'b1;
        tick(3);
        peek();
        check_lvl(ch & ih, 1'b1);
        check_lvl(cg | ig, 1'b0);
        rd_chk(8'h05, 8'h30);
        rd_chk(8'h06, 8'h30);
        sense.core_short <= 1'b0;
        sense.io_short <= 1'b0;
        sense.core_ilim <= 1'b0;
        sense.io_ilim <= 1'b0;
        tick(2);
        i_pfs_host.clear_faults();
        peek();
        check_lvl(ch | ih | !irq_n, 1'b0);
        tick(1);
        cen <= 1'b0;
        tick(2);
        peek();
        check_lvl(crun, 1'b0);
        check_lvl(irun & e5 & e12 & irq_n, 1'b1);
        tick(1);
        cen <= 1'b1;
        sense.in12_melt <= 1'b1;
        tick(2);
        sense.in12_melt <= 1'b0;
        tick(5);
        peek();
        check_lvl(e12, 1'b0);
        tick(1);
        sense.in12_uvlo <= 1'b1;
        tick(2);
        sense.in12_uvlo <= 1'b0;
        tick(3);
        peek();
        check_lvl(e12, 1'b1);
        tick(1);
        sense.in5_melt <= 1'b1;
        tick(2);
        sense.in5_melt <= 1'b0;
        tick(5);
        peek();
        check_lvl(e5, 1'b0);
        check_lvl(crun | irun, 1'b0);
        tick(1);
        pin <= 1'b1;
        tick(2);
        pin <= 1'b0;
        tick(3);
        peek();
        check_lvl(e5, 1'b1);
        i_pfs_host.clear_faults();
        sense.backup_uv <= 1'b1;
        tick(3);
        peek();
        check_lvl(irq_n | e12 | e5 | crun, 1'b0);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h06, 8'h00);
        tick(2);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
